// >>> rtl/mfc_crc_step.v
// One shift-and-conditional-XOR step of the RTU CRC.
`timescale 1ns/1ps
`default_nettype none
`include "mfc_defines.vh"
module mfc_crc_step (
    // Accumulator in and out
    input wire [15:0] i_crc,
    output wire [15:0] o_crc
);
    assign o_crc = i_crc[0] ? ((i_crc >> 1) ^ `MFC_CRC_POLY) : (i_crc >> 1);
endmodule // mfc_crc_step
`default_nettype wire

// >>> rtl/mfc_defines.vh
// Constants for the Modbus frame checksum host controller.
`ifndef MFC_DEFINES_VH
`define MFC_DEFINES_VH
`define MFC_CRC_PRESET 16'hFFFF
`define MFC_CRC_POLY 16'hA001
`define MFC_CRC_ZERO 16'h0000
`define MFC_BYTE_ZERO 8'h00
`define MFC_BITS_PER_BYTE 4'h8
`define MFC_CNT_ZERO 4'h0
`define MFC_CNT_ONE 4'h1
`define MFC_START_CHAR 8'h3A
`define MFC_CHAR_CR 8'h0D
`define MFC_CHAR_LF 8'h0A
`define MFC_CHAR_0 8'h30
`define MFC_CHAR_A_MINUS_10 8'h37
`define MFC_NIB_NINE 4'h9
`define MFC_CMD_WRITE_MULTI 8'h10
`define MFC_MODE_RTU 1'b0
`define MFC_MODE_ASCII 1'b1
`endif

// >>> rtl/mfc_host_frame.v
// Host-side Modbus frame builder with LRC and CRC generation and checking.
// Overview of operation
// - ASCII LRC sums bytes address through data, modulo 256
// - LRC is negated sum, sent as hex
// - CRC preset to all ones per frame
// - Each byte XORed into CRC low byte
// - Shift right, zero in, examine LSB
// - LSB one: XOR with reflected polynomial
// - Exactly eight steps per byte
// - Repeat per byte; final accumulator is CRC
// - Send CRC low byte, then high byte
// - Function 16 carries address, count, bytes, data, CRC
// - ASCII frame starts with colon, LRC two chars
`timescale 1ns/1ps
`default_nettype none
`include "mfc_defines.vh"
module mfc_host_frame (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst_n,
    // Mode select, sampled at frame start
    input wire i_mode_ascii,
    // Transmit request: frame payload bytes from the user
    input wire i_tx_start,
    input wire i_tx_valid,
    input wire [7:0] i_tx_byte,
    input wire i_tx_last,
    // Character stream towards the serial port
    output wire o_ser_valid,
    output wire [7:0] o_ser_char,
    input wire i_ser_ready,
    // Receive check: bytes of a reply, check bytes included
    input wire i_rx_start,
    input wire i_rx_valid,
    input wire [7:0] i_rx_byte,
    input wire i_rx_last,
    output wire o_rx_done,
    output wire o_rx_error,
    // Status
    output wire o_tx_ready,
    output wire o_tx_busy,
    output wire [15:0] o_crc
);
    ////////////////////////////////////////////////////////////////////////
    localparam [7:0] ST_IDLE = 8'h01;
    localparam [7:0] ST_WAIT = 8'h02;
    localparam [7:0] ST_CRC = 8'h04;
    localparam [7:0] ST_SEND = 8'h08;
    localparam [7:0] ST_CHK0 = 8'h10;
    localparam [7:0] ST_CHK1 = 8'h20;
    localparam [7:0] ST_END0 = 8'h40;
    localparam [7:0] ST_END1 = 8'h80;

    reg [7:0] state_reg, state_next;
    reg mode_reg, mode_next;
    reg [15:0] crc_reg, crc_next;
    reg [7:0] lrc_reg, lrc_next;
    reg [3:0] cnt_reg, cnt_next;
    reg [7:0] byte_reg, byte_next;
    reg [1:0] nib_reg, nib_next;
    reg last_reg, last_next;
    reg start_sent_reg, start_sent_next;
    reg ser_valid_reg, ser_valid_next;
    reg [7:0] ser_char_reg, ser_char_next;
    reg ready_reg, ready_next;
    reg busy_reg;
    wire [15:0] step_out;

    // Converts a nibble to its upper-case ASCII hex character.
    function [7:0] hex_char;
        input [3:0] nib;
        begin
            if (nib > `MFC_NIB_NINE) begin
                hex_char = {4'h0, nib} + `MFC_CHAR_A_MINUS_10;
            end else begin
                hex_char = {4'h0, nib} + `MFC_CHAR_0;
            end
        end
    endfunction

    // Converts an ASCII hex character back to a nibble.
    function [3:0] hex_val;
        input [7:0] c;
        begin
            if (c > 8'h39) begin
                hex_val = c[3:0] + 4'h9;
            end else begin
                hex_val = c[3:0];
            end
        end
    endfunction

    mfc_crc_step u_step (
        .i_crc(crc_reg),
        .o_crc(step_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Transmit path. One byte per strobe, then eight CRC steps in RTU mode.
    always @* begin
        state_next = state_reg;
        mode_next = mode_reg;
        crc_next = crc_reg;
        lrc_next = lrc_reg;
        cnt_next = cnt_reg;
        byte_next = byte_reg;
        nib_next = nib_reg;
        last_next = last_reg;
        start_sent_next = start_sent_reg;
        ser_valid_next = ser_valid_reg;
        ser_char_next = ser_char_reg;
        ready_next = ready_reg;
        if (ser_valid_reg && i_ser_ready) begin
            ser_valid_next = 1'b0;
        end
        case (state_reg)
            ST_IDLE: begin
                if (i_tx_start) begin
                    mode_next = i_mode_ascii;
                    crc_next = `MFC_CRC_PRESET;
                    lrc_next = `MFC_BYTE_ZERO;
                    start_sent_next = 1'b0;
                    // Text frames keep ready low until the colon has gone out.
                    ready_next = (i_mode_ascii == `MFC_MODE_RTU);
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!ser_valid_next && mode_reg == `MFC_MODE_ASCII && !start_sent_reg) begin
                    ser_valid_next = 1'b1;
                    ser_char_next = `MFC_START_CHAR;
                    start_sent_next = 1'b1;
                    ready_next = 1'b0;
                end else if (ready_reg && i_tx_valid) begin
                    byte_next = i_tx_byte;
                    last_next = i_tx_last;
                    ready_next = 1'b0;
                    nib_next = 2'b00;
                    if (mode_reg == `MFC_MODE_ASCII) begin
                        lrc_next = lrc_reg + i_tx_byte;
                        state_next = ST_SEND;
                    end else begin
                        crc_next = {crc_reg[15:8], crc_reg[7:0] ^ i_tx_byte};
                        cnt_next = `MFC_CNT_ZERO;
                        state_next = ST_CRC;
                    end
                end else if (!ser_valid_next) begin
                    ready_next = 1'b1;
                end
            end
            ST_CRC: begin
                crc_next = step_out;
                cnt_next = cnt_reg + `MFC_CNT_ONE;
                if (cnt_reg == `MFC_BITS_PER_BYTE - `MFC_CNT_ONE) begin
                    state_next = ST_SEND;
                end
            end
            ST_SEND: begin
                if (!ser_valid_next) begin
                    ser_valid_next = 1'b1;
                    if (mode_reg == `MFC_MODE_ASCII) begin
                        ser_char_next = nib_reg[0] ? hex_char(byte_reg[3:0]) :
                            hex_char(byte_reg[7:4]);
                        nib_next = nib_reg + 2'b01;
                    end else begin
                        ser_char_next = byte_reg;
                        nib_next = 2'b10;
                    end
                    if (nib_next == 2'b10) begin
                        state_next = last_reg ? ST_CHK0 : ST_WAIT;
                    end
                end
            end
            ST_CHK0: begin
                if (!ser_valid_next) begin
                    ser_valid_next = 1'b1;
                    if (mode_reg == `MFC_MODE_ASCII) begin
                        lrc_next = `MFC_BYTE_ZERO - lrc_reg;
                        ser_char_next = hex_char(lrc_next[7:4]);
                    end else begin
                        ser_char_next = crc_reg[7:0];
                    end
                    state_next = ST_CHK1;
                end
            end
            ST_CHK1: begin
                if (!ser_valid_next) begin
                    ser_valid_next = 1'b1;
                    if (mode_reg == `MFC_MODE_ASCII) begin
                        ser_char_next = hex_char(lrc_reg[3:0]);
                        state_next = ST_END0;
                    end else begin
                        ser_char_next = crc_reg[15:8];
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_END0: begin
                if (!ser_valid_next) begin
                    ser_valid_next = 1'b1;
                    ser_char_next = `MFC_CHAR_CR;
                    state_next = ST_END1;
                end
            end
            ST_END1: begin
                if (!ser_valid_next) begin
                    ser_valid_next = 1'b1;
                    ser_char_next = `MFC_CHAR_LF;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= ST_IDLE;
            mode_reg <= `MFC_MODE_RTU;
            crc_reg <= `MFC_CRC_PRESET;
            lrc_reg <= `MFC_BYTE_ZERO;
            cnt_reg <= `MFC_CNT_ZERO;
            byte_reg <= `MFC_BYTE_ZERO;
            nib_reg <= 2'b00;
            last_reg <= 1'b0;
            start_sent_reg <= 1'b0;
            ser_valid_reg <= 1'b0;
            ser_char_reg <= `MFC_BYTE_ZERO;
            ready_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            crc_reg <= crc_next;
            lrc_reg <= lrc_next;
            cnt_reg <= cnt_next;
            byte_reg <= byte_next;
            nib_reg <= nib_next;
            last_reg <= last_next;
            start_sent_reg <= start_sent_next;
            ser_valid_reg <= ser_valid_next;
            ser_char_reg <= ser_char_next;
            ready_reg <= ready_next;
            busy_reg <= (state_next != ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive check. RTU: CRC over the whole reply including its check bytes
    // comes out zero when intact. ASCII: bytes given as raw characters after
    // the colon, through the LRC pair; sum of data plus LRC is zero when intact.
    reg rx_mode_reg;
    reg [15:0] rx_crc_reg;
    reg [7:0] rx_lrc_reg;
    reg [7:0] rx_hi_reg;
    reg rx_odd_reg;
    reg rx_done_reg;
    reg rx_err_reg;
    reg [15:0] rx_c;
    reg [7:0] rx_l;
    reg [7:0] rx_pair;
    integer k;

    always @* begin
        rx_c = {rx_crc_reg[15:8], rx_crc_reg[7:0] ^ i_rx_byte};
        for (k = 0; k < `MFC_BITS_PER_BYTE; k = k + 1) begin
            rx_c = rx_c[0] ? ((rx_c >> 1) ^ `MFC_CRC_POLY) : (rx_c >> 1);
        end
        rx_pair = {rx_hi_reg[3:0], hex_val(i_rx_byte)};
        rx_l = rx_lrc_reg + rx_pair;
    end

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_mode_reg <= `MFC_MODE_RTU;
            rx_crc_reg <= `MFC_CRC_PRESET;
            rx_lrc_reg <= `MFC_BYTE_ZERO;
            rx_hi_reg <= `MFC_BYTE_ZERO;
            rx_odd_reg <= 1'b0;
            rx_done_reg <= 1'b0;
            rx_err_reg <= 1'b0;
        end else begin
            rx_done_reg <= 1'b0;
            if (i_rx_valid) begin
                if (rx_mode_reg == `MFC_MODE_ASCII) begin
                    rx_odd_reg <= ~rx_odd_reg;
                    rx_hi_reg <= {4'h0, hex_val(i_rx_byte)};
                    if (rx_odd_reg) begin
                        rx_lrc_reg <= rx_l;
                    end
                    if (i_rx_last) begin
                        rx_done_reg <= 1'b1;
                        rx_err_reg <= !rx_odd_reg || (rx_l != `MFC_BYTE_ZERO);
                    end
                end else begin
                    rx_crc_reg <= rx_c;
                    if (i_rx_last) begin
                        rx_done_reg <= 1'b1;
                        rx_err_reg <= (rx_c != `MFC_CRC_ZERO);
                    end
                end
            end
            // A frame that ends in the cycle of a new start still reports its error.
            if (i_rx_start) begin
                rx_mode_reg <= i_mode_ascii;
                rx_crc_reg <= `MFC_CRC_PRESET;
                rx_lrc_reg <= `MFC_BYTE_ZERO;
                rx_odd_reg <= 1'b0;
                if (!(i_rx_valid && i_rx_last)) begin
                    rx_err_reg <= 1'b0;
                end
            end
        end
    end

    assign o_ser_valid = ser_valid_reg;
    assign o_ser_char = ser_char_reg;
    assign o_tx_ready = ready_reg;
    assign o_tx_busy = busy_reg;
    assign o_crc = crc_reg;
    assign o_rx_done = rx_done_reg;
    assign o_rx_error = rx_err_reg;
endmodule // mfc_host_frame
`default_nettype wire

// >>> sim/mfc_drive_sink.sv
// Character sink that stands for the drive on the serial side.
`timescale 1ns/1ps
`default_nettype none
module mfc_drive_sink (
    // Clock
    input wire i_clk_sys,
    // Character stream
    input wire i_valid,
    input wire [7:0] i_char,
    output logic o_ready,
    // Stall control: when high, ready toggles every cycle
    input wire i_stall
);
    logic [7:0] rx_q [$];
    initial o_ready = 1'h0;
    always @(posedge i_clk_sys) begin
        if (i_valid && o_ready) rx_q.push_back(i_char);
        #1 o_ready = i_stall ? !o_ready : 1'h1;
    end
endmodule // mfc_drive_sink
`default_nettype wire

// >>> sim/mfc_host_frame_sva.sv
// Assertion checker for the Modbus frame host controller.
`timescale 1ns/1ps
`default_nettype none
module mfc_host_frame_sva (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst_n,
    // Transmit side
    input wire i_mode_ascii,
    input wire i_tx_start,
    input wire i_tx_valid,
    input wire o_ser_valid,
    input wire [7:0] o_ser_char,
    input wire i_ser_ready,
    // Receive side and status
    input wire i_rx_start,
    input wire i_rx_valid,
    input wire i_rx_last,
    input wire o_rx_done,
    input wire o_rx_error,
    input wire o_tx_ready,
    input wire o_tx_busy,
    input wire [15:0] o_crc
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // Frame mode and a flag that marks the first character still to come.
    reg ascii_reg;
    reg first_reg;
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ascii_reg <= 1'h0;
            first_reg <= 1'h0;
        end else if (i_tx_start && !o_tx_busy) begin
            ascii_reg <= i_mode_ascii;
            first_reg <= 1'h1;
        end else if (o_ser_valid) begin
            first_reg <= 1'h0;
        end
    end
    a_ser_hold: assert property (o_ser_valid && !i_ser_ready |=> o_ser_valid && $stable(o_ser_char))
        else $error("character changed before it was accepted");
    a_eight_steps: assert property (!ascii_reg && o_tx_ready && i_tx_valid |=> (!o_ser_valid)[*7] ##[1:4] o_ser_valid)
        else $error("byte left before eight shift steps");
    a_crc_preset: assert property (i_tx_start && !o_tx_busy && !i_mode_ascii |=> o_crc == 16'hFFFF)
        else $error("accumulator not preset at frame start");
    a_colon_first: assert property (ascii_reg && first_reg && o_ser_valid |-> o_ser_char == 8'h3A)
        else $error("text frame does not open with a colon");
    a_ready_once: assert property (o_tx_ready && i_tx_valid |=> !o_tx_ready)
        else $error("ready stayed up after a byte was taken");
    a_done_pulse: assert property (o_rx_done |=> !o_rx_done)
        else $error("done longer than one cycle");
    a_done_cause: assert property (o_rx_done |-> $past(i_rx_valid && i_rx_last))
        else $error("done without a last byte before it");
    a_err_clear: assert property (i_rx_start && !(i_rx_valid && i_rx_last) |=> !o_rx_error)
        else $error("error flag not cleared by a new start");
    a_err_hold: assert property (o_rx_error && !i_rx_start |=> o_rx_error)
        else $error("error flag dropped without a new start");
endmodule // mfc_host_frame_sva
bind mfc_host_frame mfc_host_frame_sva u_sva (.i_clk_sys, .i_rst_n, .i_mode_ascii, .i_tx_start,
    .i_tx_valid, .o_ser_valid, .o_ser_char, .i_ser_ready, .i_rx_start, .i_rx_valid, .i_rx_last,
    .o_rx_done, .o_rx_error, .o_tx_ready, .o_tx_busy, .o_crc);
`default_nettype wire

// >>> sim/tb_mfc_host_frame.sv
// Testbench for the Modbus frame host controller.
`timescale 1ns/1ps
`default_nettype none
module tb_mfc_host_frame;
    logic i_clk_sys, i_rst_n, mode, tx_start, tx_valid, tx_last, rx_start, rx_valid, rx_last, stall;
    logic [7:0] tx_byte, rx_byte;
    wire ser_valid, ser_ready, rx_done, rx_error, tx_ready, tx_busy;
    wire [7:0] ser_char;
    wire [15:0] crc;
    int err_count = 0;
    int checked = 0;
    mfc_host_frame uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_mode_ascii(mode),
        .i_tx_start(tx_start), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte), .i_tx_last(tx_last),
        .o_ser_valid(ser_valid), .o_ser_char(ser_char), .i_ser_ready(ser_ready),
        .i_rx_start(rx_start), .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .i_rx_last(rx_last),
        .o_rx_done(rx_done), .o_rx_error(rx_error), .o_tx_ready(tx_ready), .o_tx_busy(tx_busy),
        .o_crc(crc));
    mfc_drive_sink u_sink (.i_clk_sys(i_clk_sys), .i_valid(ser_valid), .i_char(ser_char),
        .o_ready(ser_ready), .i_stall(stall));
    initial begin
        i_clk_sys = 1'h0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [15:0] crc16(input logic [7:0] b [$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction
    // Text form of a payload: two hex characters per byte, then the check value.
    function automatic void to_text(input logic [7:0] b [$], output logic [7:0] t [$]);
        logic [7:0] s;
        s = 8'h00;
        t = {};
        foreach (b[i]) s = s + b[i];
        s = 8'h00 - s;
        foreach (b[i]) t = {t, hx(b[i][7:4]), hx(b[i][3:0])};
        t = {t, hx(s[7:4]), hx(s[3:0])};
    endfunction
    task automatic wait_low(input logic m);
        int k;
        k = 0;
        while (tx_busy !== 1'h0 && k < 50) begin
            @(negedge i_clk_sys);
            k++;
        end
        if (k >= 50) begin
            err_count++;
            results();
        end
    endtask
    task automatic tx_frame(input logic m, input logic [7:0] b [$]);
        logic [7:0] e [$];
        logic [15:0] c;
        int k;
        c = crc16(b);
        if (m) begin
            to_text(b, e);
            e = {8'h3A, e, 8'h0D, 8'h0A};
        end else e = {b, c[7:0], c[15:8]};
        u_sink.rx_q.delete();
        mode = m;
        tx_start = 1'h1;
        @(posedge i_clk_sys);
        #1 tx_start = 1'h0;
        foreach (b[i]) begin
            tx_byte = b[i];
            tx_last = (i == b.size() - 1);
            tx_valid = 1'h1;
            k = 0;
            do begin
                @(negedge i_clk_sys);
                k++;
            end while (tx_ready !== 1'h1 && k < 200);
            if (k >= 200) begin
                err_count++;
                results();
            end
            @(posedge i_clk_sys);
            #1;
        end
        tx_valid = 1'h0;
        tx_last = 1'h0;
        k = 0;
        while (u_sink.rx_q.size() < e.size() && k < 400) begin
            @(negedge i_clk_sys);
            k++;
        end
        chk("char count", e.size(), u_sink.rx_q.size());
        foreach (e[i]) chk("char", e[i], u_sink.rx_q[i]);
        if (!m) chk("crc", c, crc);
        wait_low(m);
    endtask
    task automatic rx_frame(input logic m, input logic [7:0] b [$], input logic x);
        int k;
        mode = m;
        rx_start = 1'h1;
        @(posedge i_clk_sys);
        #1 rx_start = 1'h0;
        foreach (b[i]) begin
            rx_valid = 1'h1;
            rx_byte = b[i];
            rx_last = (i == b.size() - 1);
            @(posedge i_clk_sys);
            #1;
        end
        rx_valid = 1'h0;
        rx_last = 1'h0;
        k = 0;
        while (rx_done !== 1'h1 && k < 8) begin
            @(negedge i_clk_sys);
            k++;
        end
        chk("rx done", 1'h1, rx_done);
        chk("rx error", x, rx_error);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_rtu_read;
        tx_frame(1'h0, '{8'h01, 8'h03, 8'h21, 8'h02, 8'h00, 8'h02});
        chk("known crc", 16'hF76F, crc);
        $display("test rtu read done");
    endtask
    task t_rtu_write_stalled;
        stall = 1'h1;
        tx_frame(1'h0, '{8'h01, 8'h10, 8'h20, 8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 8'h02,
            8'h02, 8'h58});
        chk("known crc", 16'h34CB, crc);
        stall = 1'h0;
        $display("test rtu write stalled done");
    endtask
    task t_ascii_tx;
        tx_frame(1'h1, '{8'h01, 8'h03, 8'h04, 8'h01, 8'h00, 8'h01});
        $display("test ascii transmit done");
    endtask
    task automatic t_rx_check;
        logic [7:0] t [$];
        rx_frame(1'h0, '{8'h01, 8'h10, 8'h20, 8'h00, 8'h00, 8'h02, 8'h4A, 8'h08}, 1'h0);
        rx_frame(1'h0, '{8'h01, 8'h10, 8'h20, 8'h00, 8'h00, 8'h02, 8'h4B, 8'h08}, 1'h1);
        to_text('{8'h01, 8'h03, 8'h04, 8'h01, 8'h00, 8'h01}, t);
        chk("lrc char", 8'h36, t[t.size() - 1]);
        rx_frame(1'h1, t, 1'h0);
        t[t.size() - 1] = 8'h37;
        rx_frame(1'h1, t, 1'h1);
        $display("test receive check done");
    endtask
    initial begin
        i_rst_n = 1'h0;
        {mode, tx_start, tx_valid, tx_last, rx_start, rx_valid, rx_last, stall} = 8'h00;
        tx_byte = 8'h00;
        rx_byte = 8'h00;
        repeat (10) @(posedge i_clk_sys);
        chk("reset crc", 16'hFFFF, crc);
        #1 i_rst_n = 1'h1;
        t_rtu_read();
        t_rtu_write_stalled();
        t_ascii_tx();
        t_rx_check();
        results();
    end
endmodule // tb_mfc_host_frame
`default_nettype wire
